// ### rtl/instr_timing_consts.svh
// Timing, length and address constants for the instruction timing block
`ifndef INSTR_TIMING_CONSTS_SVH
`define INSTR_TIMING_CONSTS_SVH
`define SFR_SPACE_BASE   8'h80
`define DIRECT_RAM_TOP   8'h7F
`define LEN_ONE          2'h1
`define LEN_TWO          2'h2
`define LEN_THREE        2'h3
`define CYC_ONE          4'h1
`define CYC_TWO          4'h2
`define CYC_THREE        4'h3
`define CYC_MUL          4'h4
`define CYC_DIV          4'h8
`define OPC_MUL          8'hA4
`define OPC_DIV          8'h84
`define OPC_MOV_DIR_DIR  8'h85
`define OPC_MOV_PTR_IMM  8'h90
`define OPC_CODE_PTR     8'h93
`define OPC_CODE_PC      8'h83
`define OPC_XMOV_RD_DP   8'hE0
`define OPC_XMOV_WR_DP   8'hF0
`define OPC_PUSH         8'hC0
`define OPC_POP          8'hD0
`define OPC_MOV_DIR_IND  8'h86
`endif

// ### rtl/instr_timing_pkg.sv
// Types shared by the instruction timing block
package instr_timing_pkg;
  typedef enum logic [1:0] {
    XT_NONE,
    XT_EXT_RAM,
    XT_OFFCHIP,
    XT_FLASH
  } xdata_target_t;
endpackage

// ### rtl/cycle_counter.sv
// Cycle counter that holds an instruction for its documented clock count
`timescale 1ns/100ps
module cycle_counter (
  input  wire logic       i_sys_clk,
  input  wire logic       i_rst,
  input  wire logic       i_start,
  input  wire logic [3:0] i_cycles,
  output logic            o_busy,
  output logic            o_last
);
  logic [3:0] remaining;

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      remaining <= 4'h0;
    end else if (i_start && !o_busy) begin
      remaining <= i_cycles - 4'h1;
    end else if (remaining != 4'h0) begin
      remaining <= remaining - 4'h1;
    end
  end

  assign o_busy = (remaining != 4'h0);
  assign o_last = (remaining == 4'h1) || (i_start && !o_busy && i_cycles == 4'h1);
endmodule

// ### rtl/core_instr_timing_datapath.sv
// Instruction length/cycle decoder and operand routing for the 8-bit core
// ----------------------------------------
// Operation
// ----------------------------------------
// ----------------------------------------
`timescale 1ns/100ps
`include "instr_timing_consts.svh"
module core_instr_timing_datapath (
  input  wire logic                         i_sys_clk,
  input  wire logic                         i_rst,
  input  wire logic                         i_issue,
  input  wire logic [7:0]                   i_opcode,
  input  wire logic [7:0]                   i_direct_addr,
  input  wire logic [1:0]                   i_bank_select,
  input  wire logic                         i_flash_access_en,
  input  wire logic                         i_emif_present,
  input  wire logic [15:0]                  i_xdata_addr,
  input  wire logic [15:0]                  i_ext_ram_size,
  output logic                              o_ready,
  output logic                              o_done,
  output logic [1:0]                        o_length,
  output logic [3:0]                        o_cycles,
  output logic                              o_direct_is_sfr,
  output logic [4:0]                        o_bank_reg_addr,
  output logic                              o_writes_direct,
  output instr_timing_pkg::xdata_target_t   o_xdata_target,
  output logic                              o_emif_request
);
  // ----------------------------------------
  // Opcode classification
  // ----------------------------------------
  wire [3:0] hi = i_opcode[7:4];
  wire [3:0] lo = i_opcode[3:0];
  wire is_alu_hi    = (hi == 4'h2) || (hi == 4'h3) || (hi == 4'h9)
                    || (hi == 4'h4) || (hi == 4'h5) || (hi == 4'h6);
  wire is_logic_hi  = (hi == 4'h4) || (hi == 4'h5) || (hi == 4'h6);
  wire is_reg_op    = i_opcode[3];
  wire is_ind_op    = (lo == 4'h6) || (lo == 4'h7);
  wire alu_reg      = is_alu_hi && is_reg_op;
  wire alu_dir      = is_alu_hi && (lo == 4'h5);
  wire alu_ind      = is_alu_hi && is_ind_op;
  wire alu_imm      = is_alu_hi && (lo == 4'h4);
  wire logic_dir_a  = is_logic_hi && (lo == 4'h2);
  wire logic_dir_im = is_logic_hi && (lo == 4'h3);
  wire acc_unary    = (i_opcode == 8'h03) || (i_opcode == 8'h13) || (i_opcode == 8'h23)
                    || (i_opcode == 8'h33) || (i_opcode == 8'hE4) || (i_opcode == 8'hF4)
                    || (i_opcode == 8'hC4);
  wire mov_dir_dir  = (i_opcode == `OPC_MOV_DIR_DIR);
  wire mov_dir_ind  = (i_opcode[7:1] == 7'h43);
  wire mov_ind_acc  = (i_opcode[7:1] == 7'h7B);
  wire ptr_load     = (i_opcode == `OPC_MOV_PTR_IMM);
  wire code_read    = (i_opcode == `OPC_CODE_PTR) || (i_opcode == `OPC_CODE_PC);
  wire xmov_ri      = (i_opcode[7:1] == 7'h71) || (i_opcode[7:1] == 7'h79);
  wire xmov_dp      = (i_opcode == `OPC_XMOV_RD_DP) || (i_opcode == `OPC_XMOV_WR_DP);
  wire push_pop     = (i_opcode == `OPC_PUSH) || (i_opcode == `OPC_POP);
  wire nib_xchg     = (i_opcode[7:1] == 7'h6B);
  wire xch_reg      = (hi == 4'hC) && is_reg_op;
  wire is_mul       = (i_opcode == `OPC_MUL);
  wire is_div       = (i_opcode == `OPC_DIV);
  wire is_xmov      = xmov_ri || xmov_dp;

  // ----------------------------------------
  // Length and cycle lookup, plain clocks
  // ----------------------------------------
  logic [1:0] next_length;
  logic [3:0] next_cycles;
  always_comb begin
    next_length = `LEN_ONE;
    next_cycles = `CYC_ONE;
    if (is_mul) begin
      next_cycles = `CYC_MUL;
    end else if (is_div) begin
      next_cycles = `CYC_DIV;
    end else if (logic_dir_im || mov_dir_dir || ptr_load) begin
      next_length = `LEN_THREE;
      next_cycles = `CYC_THREE;
    end else if (code_read || is_xmov) begin
      next_cycles = `CYC_THREE;
    end else if (alu_dir || alu_imm || logic_dir_a || mov_dir_ind || push_pop) begin
      next_length = `LEN_TWO;
      next_cycles = `CYC_TWO;
    end else if (alu_ind || mov_ind_acc || nib_xchg) begin
      next_cycles = `CYC_TWO;
    end else if (alu_reg || acc_unary || xch_reg) begin
      next_cycles = `CYC_ONE;
    end
  end

  // ----------------------------------------
  // External data target routing
  // ----------------------------------------
  instr_timing_pkg::xdata_target_t next_target;
  wire in_ext_ram = (i_xdata_addr < i_ext_ram_size);
  always_comb begin
    if (!is_xmov) begin
      next_target = instr_timing_pkg::XT_NONE;
    end else if (i_flash_access_en) begin
      next_target = instr_timing_pkg::XT_FLASH;
    end else if (in_ext_ram || !i_emif_present) begin
      next_target = instr_timing_pkg::XT_EXT_RAM;
    end else begin
      next_target = instr_timing_pkg::XT_OFFCHIP;
    end
  end

  // ----------------------------------------
  // Issue and hold
  // ----------------------------------------
  logic busy;
  logic last;
  wire  take = i_issue && o_ready;
  cycle_counter u_cycles (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .i_start   (take),
    .i_cycles  (next_cycles),
    .o_busy    (busy),
    .o_last    (last)
  );
  assign o_ready = !busy;
  assign o_done  = last;

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_length        <= 2'h0;
      o_cycles        <= 4'h0;
      o_direct_is_sfr <= 1'b0;
      o_bank_reg_addr <= 5'h00;
      o_writes_direct <= 1'b0;
      o_xdata_target  <= instr_timing_pkg::XT_NONE;
      o_emif_request  <= 1'b0;
    end else if (take) begin
      o_length        <= next_length;
      o_cycles        <= next_cycles;
      o_direct_is_sfr <= (i_direct_addr >= `SFR_SPACE_BASE);
      o_bank_reg_addr <= {i_bank_select, i_opcode[2:0]};
      o_writes_direct <= logic_dir_a || logic_dir_im;
      o_xdata_target  <= next_target;
      o_emif_request  <= (next_target == instr_timing_pkg::XT_OFFCHIP);
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_mul_four;
    @(posedge i_sys_clk) disable iff (i_rst)
    (take && is_mul) |=> !o_ready [*3] ##1 o_ready;
  endproperty
  a_mul_four: assert property (p_mul_four) else $error("multiply not 4 cycles");

  property p_div_eight;
    @(posedge i_sys_clk) disable iff (i_rst)
    (take && is_div) |=> !o_ready [*7] ##1 o_ready;
  endproperty
  a_div_eight: assert property (p_div_eight) else $error("divide not 8 cycles");

  property p_three_bytes;
    @(posedge i_sys_clk) disable iff (i_rst)
    (take && (logic_dir_im || mov_dir_dir || ptr_load)) |=> (o_length == 2'h3 && o_cycles == 4'h3);
  endproperty
  a_three_bytes: assert property (p_three_bytes) else $error("three byte group wrong");

  property p_xmov_three;
    @(posedge i_sys_clk) disable iff (i_rst)
    (take && is_xmov) |=> !o_ready [*2] ##1 o_ready;
  endproperty
  a_xmov_three: assert property (p_xmov_three) else $error("external move not 3 cycles");

  property p_single_cycle;
    @(posedge i_sys_clk) disable iff (i_rst)
    (take && (alu_reg || acc_unary || xch_reg)) |-> o_done ##1 o_ready;
  endproperty
  a_single_cycle: assert property (p_single_cycle) else $error("single cycle op stalled");

  property p_ind_two;
    @(posedge i_sys_clk) disable iff (i_rst)
    (take && (alu_ind || mov_ind_acc || nib_xchg)) |=> (o_length == 2'h1 && o_cycles == 4'h2);
  endproperty
  a_ind_two: assert property (p_ind_two) else $error("indirect op timing wrong");

  property p_sfr_split;
    @(posedge i_sys_clk) disable iff (i_rst)
    take |=> (o_direct_is_sfr == $past(i_direct_addr[7]));
  endproperty
  a_sfr_split: assert property (p_sfr_split) else $error("direct space select wrong");

  property p_emif_route;
    @(posedge i_sys_clk) disable iff (i_rst)
    (take && is_xmov && !i_flash_access_en && !in_ext_ram && i_emif_present) |=> o_emif_request;
  endproperty
  a_emif_route: assert property (p_emif_route) else $error("off-chip move missed interface");

  property p_flash_route;
    @(posedge i_sys_clk) disable iff (i_rst)
    (take && is_xmov && i_flash_access_en) |=> (o_xdata_target == instr_timing_pkg::XT_FLASH);
  endproperty
  a_flash_route: assert property (p_flash_route) else $error("flash route wrong");

  // Raw opcode checks up to a_bank_addr, kept apart from the decode wires so a slip in them shows up
  property p_two_direct;
    @(posedge i_sys_clk) disable iff (i_rst)
    (take && (i_opcode inside {8'h25, 8'h35, 8'h95, 8'h45, 8'h55, 8'h65})) |=> (o_length == 2'h2 && o_cycles == 4'h2);
  endproperty
  a_two_direct: assert property (p_two_direct) else $error("direct into accumulator timing wrong");

  property p_imm_acc;
    @(posedge i_sys_clk) disable iff (i_rst)
    (take && (i_opcode inside {8'h24, 8'h34, 8'h94, 8'h44, 8'h54, 8'h64})) |=> (o_length == 2'h2 && o_cycles == 4'h2);
  endproperty
  a_imm_acc: assert property (p_imm_acc) else $error("immediate with accumulator timing wrong");

  property p_acc_to_dir;
    @(posedge i_sys_clk) disable iff (i_rst)
    (take && (i_opcode inside {8'h42, 8'h52, 8'h62})) |=> (o_length == 2'h2 && o_cycles == 4'h2 && o_writes_direct);
  endproperty
  a_acc_to_dir: assert property (p_acc_to_dir) else $error("accumulator into direct byte wrong");

  property p_dir_move;
    @(posedge i_sys_clk) disable iff (i_rst)
    (take && i_opcode == 8'h85) |=> (o_length == 2'h3 && o_cycles == 4'h3 && !o_writes_direct);
  endproperty
  a_dir_move: assert property (p_dir_move) else $error("direct to direct move wrong");

  property p_ptr_load;
    @(posedge i_sys_clk) disable iff (i_rst)
    (take && i_opcode == 8'h90) |=> (o_length == 2'h3 && o_cycles == 4'h3);
  endproperty
  a_ptr_load: assert property (p_ptr_load) else $error("pointer load timing wrong");

  property p_ind_to_dir;
    @(posedge i_sys_clk) disable iff (i_rst)
    (take && i_opcode[7:1] == 7'h43) |=> (o_length == 2'h2 && o_cycles == 4'h2);
  endproperty
  a_ind_to_dir: assert property (p_ind_to_dir) else $error("indirect to direct move wrong");

  property p_acc_store;
    @(posedge i_sys_clk) disable iff (i_rst)
    (take && i_opcode[7:1] == 7'h7B) |=> (o_length == 2'h1 && o_cycles == 4'h2);
  endproperty
  a_acc_store: assert property (p_acc_store) else $error("accumulator store timing wrong");

  property p_code_read;
    @(posedge i_sys_clk) disable iff (i_rst)
    (take && (i_opcode == 8'h93 || i_opcode == 8'h83)) |=> (o_length == 2'h1 && o_cycles == 4'h3);
  endproperty
  a_code_read: assert property (p_code_read) else $error("code byte read timing wrong");

  property p_stack;
    @(posedge i_sys_clk) disable iff (i_rst)
    (take && (i_opcode == 8'hC0 || i_opcode == 8'hD0)) |=> (o_length == 2'h2 && o_cycles == 4'h2);
  endproperty
  a_stack: assert property (p_stack) else $error("stack move timing wrong");

  property p_nibble_xchg;
    @(posedge i_sys_clk) disable iff (i_rst)
    (take && i_opcode[7:1] == 7'h6B) |=> (o_length == 2'h1 && o_cycles == 4'h2);
  endproperty
  a_nibble_xchg: assert property (p_nibble_xchg) else $error("low nibble exchange timing wrong");

  property p_reg_xchg;
    @(posedge i_sys_clk) disable iff (i_rst)
    (take && i_opcode[7:3] == 5'h19) |=> (o_length == 2'h1 && o_cycles == 4'h1);
  endproperty
  a_reg_xchg: assert property (p_reg_xchg) else $error("register exchange timing wrong");

  property p_acc_unary;
    @(posedge i_sys_clk) disable iff (i_rst)
    (take && (i_opcode inside {8'h03, 8'h13, 8'h23, 8'h33, 8'hE4, 8'hF4, 8'hC4}))
      |=> (o_length == 2'h1 && o_cycles == 4'h1);
  endproperty
  a_acc_unary: assert property (p_acc_unary) else $error("accumulator-only op timing wrong");

  property p_bank_addr;
    @(posedge i_sys_clk) disable iff (i_rst)
    take |=> (o_bank_reg_addr == {$past(i_bank_select), $past(i_opcode[2:0])});
  endproperty
  a_bank_addr: assert property (p_bank_addr) else $error("bank register address wrong");

  property p_ext_ram_route;
    @(posedge i_sys_clk) disable iff (i_rst)
    (take && is_xmov && !i_flash_access_en && (in_ext_ram || !i_emif_present))
      |=> (o_xdata_target == instr_timing_pkg::XT_EXT_RAM && !o_emif_request);
  endproperty
  a_ext_ram_route: assert property (p_ext_ram_route) else $error("on-chip route wrong");

  property p_done_then_ready;
    @(posedge i_sys_clk) disable iff (i_rst)
    o_done |=> o_ready;
  endproperty
  a_done_then_ready: assert property (p_done_then_ready) else $error("not ready after final cycle");

  property p_busy_hold;
    @(posedge i_sys_clk) disable iff (i_rst)
    !o_ready |=> ($stable(o_cycles) && $stable(o_length) && $stable(o_xdata_target));
  endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("request taken while busy");
endmodule

// ### sim/xdata_space_model.sv
// Behavioural model of the data spaces behind the external data move
`timescale 1ns/100ps
module xdata_space_model #(
  parameter logic [15:0] EXT_RAM_BYTES = 16'h1000
) (
  input  wire logic                            i_sys_clk,
  input  wire logic                            i_rst,
  input  wire instr_timing_pkg::xdata_target_t i_target,
  input  wire logic                            i_emif_request,
  output logic [15:0]                          o_ext_ram_size,
  output logic [7:0]                           o_offchip_hits
);
  // Fixed on-chip size; addresses at or above it leave the chip only when the interface is present and flash access is off
  assign o_ext_ram_size = EXT_RAM_BYTES;
  // Count each rise of the request once; the request level stands until the next take, so back-to-back off-chip moves count as one
  logic prev_request;
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_offchip_hits <= 8'h00;
      prev_request   <= 1'b0;
    end else begin
      prev_request <= i_emif_request;
      if (i_emif_request && !prev_request && i_target == instr_timing_pkg::XT_OFFCHIP) begin
        o_offchip_hits <= o_offchip_hits + 8'h01;
      end
    end
  end
endmodule

// ### sim/test_core_instr_timing_datapath.sv
// Self-checking testbench for the instruction timing and routing block
`timescale 1ns/100ps
module test_core_instr_timing_datapath;
  logic                            i_sys_clk = 1'b0;
  logic                            i_rst = 1'b1;
  logic                            i_issue = 1'b0;
  logic [7:0]                      i_opcode = 8'h00;
  logic [7:0]                      i_direct_addr = 8'h00;
  logic [1:0]                      i_bank_select = 2'h0;
  logic                            i_flash_access_en = 1'b0;
  logic                            i_emif_present = 1'b0;
  logic [15:0]                     i_xdata_addr = 16'h0000;
  logic [15:0]                     ext_ram_size;
  logic [7:0]                      offchip_hits;
  logic                            o_ready, o_done, o_direct_is_sfr, o_writes_direct, o_emif_request;
  logic [1:0]                      o_length;
  logic [3:0]                      o_cycles;
  logic [4:0]                      o_bank_reg_addr;
  instr_timing_pkg::xdata_target_t o_xdata_target;
  int                              fail_count = 0;
  int                              n_compared = 0;
  logic [15:0]                     tbl [41] = '{
    16'h2811, 16'h3811, 16'h9811,
    16'h2522, 16'h5522, 16'h2612, 16'h5612, 16'h2422, 16'h5422,
    16'h5333, 16'h4333, 16'h6333, 16'h5222, 16'h4222, 16'h6222,
    16'h5811, 16'h4811, 16'h6811,
    16'h2311, 16'h3311, 16'h0311, 16'h1311, 16'hE411, 16'hF411, 16'hC411,
    16'h8533, 16'h8622, 16'hF612, 16'h9033, 16'h9313, 16'h8313,
    16'hE213, 16'hF213, 16'hE013, 16'hF013,
    16'hC022, 16'hD022, 16'hD612, 16'hC811, 16'hA414, 16'h8418};

  always #2.5 i_sys_clk = ~i_sys_clk;

  xdata_space_model u_xdata_space_model (
    .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_target(o_xdata_target),
    .i_emif_request(o_emif_request), .o_ext_ram_size(ext_ram_size), .o_offchip_hits(offchip_hits));

  core_instr_timing_datapath u_core_instr_timing_datapath (
    .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_issue(i_issue), .i_opcode(i_opcode),
    .i_direct_addr(i_direct_addr), .i_bank_select(i_bank_select),
    .i_flash_access_en(i_flash_access_en), .i_emif_present(i_emif_present),
    .i_xdata_addr(i_xdata_addr), .i_ext_ram_size(ext_ram_size), .o_ready(o_ready),
    .o_done(o_done), .o_length(o_length), .o_cycles(o_cycles), .o_direct_is_sfr(o_direct_is_sfr),
    .o_bank_reg_addr(o_bank_reg_addr), .o_writes_direct(o_writes_direct),
    .o_xdata_target(o_xdata_target), .o_emif_request(o_emif_request));

  task automatic end_sim();
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Issue one opcode, count clocks from take to done, then check the decode
  task automatic run_op(input logic [7:0] op, input logic [3:0] len, input logic [3:0] cyc);
    int n;
    @(posedge i_sys_clk);
    i_issue <= 1'b1;
    i_opcode <= op;
    #1 n = 1;
    while (o_done !== 1'b1 && n < 20) begin
      @(posedge i_sys_clk);
      i_issue <= 1'b0;
      #1 n++;
    end
    if (n >= 20) begin
      check("done wait", 16'h0000, 16'h0001);
      end_sim();
    end else begin
      if (n == 1) begin
        @(posedge i_sys_clk);
        i_issue <= 1'b0;
        #1;
      end
      check("length", {14'h0000, len[1:0]}, {14'h0000, o_length});
      check("cycles", {12'h000, cyc}, {12'h000, o_cycles});
      check("clocks to done", {12'h000, cyc}, n[15:0]);
      check("writes direct", {15'h0000, op inside {8'h53, 8'h43, 8'h63, 8'h52, 8'h42, 8'h62}},
            {15'h0000, o_writes_direct});
      @(posedge i_sys_clk);
      #1 check("ready after", 16'h0001, {15'h0000, o_ready});
    end
  endtask

  task automatic route(input logic fl, input logic em, input logic [15:0] a,
                       input instr_timing_pkg::xdata_target_t t, input logic req);
    @(posedge i_sys_clk);
    i_flash_access_en <= fl;
    i_emif_present <= em;
    i_xdata_addr <= a;
    run_op(8'hE0, 4'h1, 4'h3);
    check("target", {14'h0000, t}, {14'h0000, o_xdata_target});
    check("emif request", {15'h0000, req}, {15'h0000, o_emif_request});
  endtask

  task automatic operand(input logic [7:0] a, input logic [1:0] b, input logic sfr);
    @(posedge i_sys_clk);
    i_direct_addr <= a;
    i_bank_select <= b;
    run_op(8'h2D, 4'h1, 4'h1);
    check("bank reg", {11'h000, b, 3'h5}, {11'h000, o_bank_reg_addr});
    run_op(8'h25, 4'h2, 4'h2);
    check("direct is sfr", {15'h0000, sfr}, {15'h0000, o_direct_is_sfr});
  endtask

  // A request held high while busy must be ignored until the divide ends
  task automatic busy_refuse();
    @(posedge i_sys_clk);
    i_issue <= 1'b1;
    i_opcode <= 8'h84;
    @(posedge i_sys_clk);
    i_opcode <= 8'h85;
    repeat (6) @(posedge i_sys_clk);
    #1 check("ready while busy", 16'h0000, {15'h0000, o_ready});
    check("done at eighth clock", 16'h0001, {15'h0000, o_done});
    @(posedge i_sys_clk);
    i_issue <= 1'b0;
    #1 check("cycles after refuse", 16'h0008, {12'h000, o_cycles});
    check("length after refuse", 16'h0001, {14'h0000, o_length});
  endtask

  initial begin
    repeat (10) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    foreach (tbl[i]) run_op(tbl[i][15:8], tbl[i][7:4], tbl[i][3:0]);
    route(1'b1, 1'b1, 16'hF000, instr_timing_pkg::XT_FLASH, 1'b0);
    route(1'b0, 1'b1, 16'h0FFF, instr_timing_pkg::XT_EXT_RAM, 1'b0);
    route(1'b0, 1'b1, 16'h1000, instr_timing_pkg::XT_OFFCHIP, 1'b1);
    route(1'b0, 1'b0, 16'h1000, instr_timing_pkg::XT_EXT_RAM, 1'b0);
    check("offchip hits", 16'h0001, {8'h00, offchip_hits});
    operand(8'h7F, 2'h2, 1'b0);
    operand(8'h80, 2'h3, 1'b1);
    busy_refuse();
    // Reset in the middle of a divide must clear it at once
    @(posedge i_sys_clk);
    i_issue <= 1'b1;
    i_opcode <= 8'h84;
    @(posedge i_sys_clk);
    i_issue <= 1'b0;
    i_rst <= 1'b1;
    @(posedge i_sys_clk);
    i_rst <= 1'b0;
    #1 check("ready at reset", 16'h0001, {15'h0000, o_ready});
    check("cycles at reset", 16'h0000, {12'h000, o_cycles});
    run_op(8'hA4, 4'h1, 4'h4);
    end_sim();
  end
endmodule
